/* File: pkg/pin_mode_pkg.sv */
// constants for the port 2 pin mode registers, pins 1 to 5
// assumes a plain register port with 32-bit byte addresses and 16-bit data
package pin_mode_pkg;
    localparam int unsigned NUM_PINS = 5;
    localparam int unsigned ADDR_W = 32;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned FID_W = 5;
    localparam int unsigned SEL_W = 2;

    // printed register offsets, one 16-bit register each
    localparam logic [31:0] PORT2_PIN1_MODE_OFS = 32'h5000_3048;
    localparam logic [31:0] PORT2_PIN2_MODE_OFS = 32'h5000_304a;
    localparam logic [31:0] PORT2_PIN3_MODE_OFS = 32'h5000_304c;
    localparam logic [31:0] PORT2_PIN4_MODE_OFS = 32'h5000_304e;
    localparam logic [31:0] PORT2_PIN5_MODE_OFS = 32'h5000_3050;

    // field positions
    localparam int unsigned SEL_LSB = 8;
    localparam int unsigned SEL_MSB = 9;
    localparam int unsigned FID_LSB = 0;
    localparam int unsigned FID_MSB = 4;

    // pull/direction encodings
    localparam logic [1:0] SEL_IN_NONE = 2'h0;
    localparam logic [1:0] SEL_IN_PULL_UP = 2'h1;
    localparam logic [1:0] SEL_IN_PULL_DOWN = 2'h2;
    localparam logic [1:0] SEL_OUTPUT = 2'h3;

    // reset values
    localparam logic [1:0] SEL_RESET = 2'h2;
    localparam logic [4:0] FID_RESET = 5'h00;
    localparam logic [15:0] READ_ZERO = 16'h0000;
endpackage : pin_mode_pkg

/* File: logic/port2_pin_mode_config.sv */
// port 2 pin mode configuration, pins 1 to 5: registers and pad control decode
// assumes a single-cycle register master; pad controls feed the pad ring directly
`timescale 1ns/100ps
module port2_pin_mode_config (
    input wire logic sys_clk, // 40 MHz system clock
    input wire logic rst_b, // synchronous reset, active low
    input wire logic [31:0] reg_addr, // register byte address
    input wire logic [15:0] reg_wr_data, // register write data
    input wire logic reg_wr, // write strobe, one cycle
    input wire logic reg_rd, // read strobe, one cycle
    output logic [15:0] reg_rd_data, // read data, valid the cycle after reg_rd
    input wire logic [4:0] pin_analog, // per pin: pad is in analog use
    output logic [4:0] pad_output_en, // per pin: output driver enabled
    output logic [4:0] pad_pull_up_en, // per pin: pull-up resistor enabled
    output logic [4:0] pad_pull_down_en, // per pin: pull-down resistor enabled
    output logic [24:0] pin_function_id // five bits per pin, pin 1 in the low bits
);

    // address decoder slot: hit flag on top of a three-bit pin index
    localparam int unsigned SLOT_W = 4;
    localparam int unsigned SLOT_HIT = 3;
    localparam int unsigned IDX_W = 3;
    localparam logic [3:0] SLOT_NONE = 4'h0;
    localparam logic [3:0] SLOT_PIN1 = 4'h8;
    localparam logic [3:0] SLOT_PIN2 = 4'h9;
    localparam logic [3:0] SLOT_PIN3 = 4'ha;
    localparam logic [3:0] SLOT_PIN4 = 4'hb;
    localparam logic [3:0] SLOT_PIN5 = 4'hc;

    // pad control word: {output enable, pull-up, pull-down}
    localparam int unsigned PAD_W = 3;
    localparam int unsigned PAD_OE = 2;
    localparam int unsigned PAD_PU = 1;
    localparam int unsigned PAD_PD = 0;
    localparam logic [2:0] PAD_ALL_OFF = 3'h0;
    localparam logic [2:0] PAD_PULL_UP = 3'h2;
    localparam logic [2:0] PAD_PULL_DOWN = 3'h1;
    localparam logic [2:0] PAD_DRIVE = 3'h4;

    // pad vectors after reset: the pulled-down input that the reset field selects
    localparam logic [4:0] PINS_NONE = 5'h00;
    localparam logic [4:0] PINS_ALL = 5'h1f;
    localparam logic [4:0] OE_RESET = PINS_NONE;
    localparam logic [4:0] PU_RESET = PINS_NONE;
    localparam logic [4:0] PD_RESET = PINS_ALL;

    // map an address to a pin slot; hit low for anything unmapped
    function automatic logic [3:0] addr_decode(input logic [31:0] a);
        logic [3:0] r;
        r = SLOT_NONE;
        case (a)
            pin_mode_pkg::PORT2_PIN1_MODE_OFS: begin
                r = SLOT_PIN1;
            end
            pin_mode_pkg::PORT2_PIN2_MODE_OFS: begin
                r = SLOT_PIN2;
            end
            pin_mode_pkg::PORT2_PIN3_MODE_OFS: begin
                r = SLOT_PIN3;
            end
            pin_mode_pkg::PORT2_PIN4_MODE_OFS: begin
                r = SLOT_PIN4;
            end
            pin_mode_pkg::PORT2_PIN5_MODE_OFS: begin
                r = SLOT_PIN5;
            end
            default: begin
                r = SLOT_NONE;
            end
        endcase
        return r;
    endfunction : addr_decode

    // {output enable, pull-up, pull-down} for one pin
    function automatic logic [2:0] pad_decode(input logic [1:0] sel, input logic analog);
        logic [2:0] r;
        r = PAD_ALL_OFF;
        if (analog) begin
            // the field keeps its value, it just stops reaching the pad
            r = PAD_ALL_OFF;
        end else begin
            case (sel)
                pin_mode_pkg::SEL_IN_NONE: begin
                    r = PAD_ALL_OFF;
                end
                pin_mode_pkg::SEL_IN_PULL_UP: begin
                    r = PAD_PULL_UP;
                end
                pin_mode_pkg::SEL_IN_PULL_DOWN: begin
                    r = PAD_PULL_DOWN;
                end
                pin_mode_pkg::SEL_OUTPUT: begin
                    r = PAD_DRIVE;
                end
                default: begin
                    r = PAD_ALL_OFF;
                end
            endcase
        end
        return r;
    endfunction : pad_decode

    // pull/direction field of a write word
    function automatic logic [1:0] wr_sel_field(input logic [15:0] d);
        logic [1:0] r;
        r = d[pin_mode_pkg::SEL_MSB:pin_mode_pkg::SEL_LSB];
        return r;
    endfunction : wr_sel_field

    // function id field of a write word; reserved bits are dropped here
    function automatic logic [4:0] wr_fid_field(input logic [15:0] d);
        logic [4:0] r;
        r = d[pin_mode_pkg::FID_MSB:pin_mode_pkg::FID_LSB];
        return r;
    endfunction : wr_fid_field

    // read word for one register, reserved bits forced to zero
    function automatic logic [15:0] read_word(input logic [1:0] sel, input logic [4:0] fid);
        logic [15:0] r;
        r = pin_mode_pkg::READ_ZERO;
        r[pin_mode_pkg::SEL_MSB:pin_mode_pkg::SEL_LSB] = sel;
        r[pin_mode_pkg::FID_MSB:pin_mode_pkg::FID_LSB] = fid;
        return r;
    endfunction : read_word

    // one-hot pin pick from a decoded slot, empty when the address missed
    function automatic logic [4:0] slot_onehot(input logic [3:0] slot);
        logic [4:0] r;
        r = PINS_NONE;
        if (slot[SLOT_HIT]) begin
            for (int i = 0; i < 5; i++) begin
                r[i] = (slot[IDX_W-1:0] == IDX_W'(i));
            end
        end
        return r;
    endfunction : slot_onehot

    // flatten the function ids, pin 1 in the low five bits
    function automatic logic [24:0] pack_fids(input logic [4:0] f0, input logic [4:0] f1,
        input logic [4:0] f2, input logic [4:0] f3, input logic [4:0] f4);
        logic [24:0] r;
        r = {f4, f3, f2, f1, f0};
        return r;
    endfunction : pack_fids

    logic [1:0] sel_q [5];
    logic [1:0] sel_d [5];
    logic [4:0] fid_q [5];
    logic [4:0] fid_d [5];
    logic [15:0] rd_data_q, rd_data_d;
    logic [4:0] oe_q, oe_d, pu_q, pu_d, pd_q, pd_d;
    logic [3:0] wr_slot, rd_slot;
    logic [4:0] wr_pick, rd_pick;

    assign wr_slot = addr_decode(reg_addr);
    assign rd_slot = wr_slot;

    // per-pin strobes; at most one bit set, since the slots are distinct
    always_comb begin
        wr_pick = PINS_NONE;
        rd_pick = PINS_NONE;
        if (reg_wr) begin
            wr_pick = slot_onehot(wr_slot);
        end
        if (reg_rd) begin
            rd_pick = slot_onehot(rd_slot);
        end
    end

    // register writes; a write to an unmapped address picks no pin
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            sel_d[i] = sel_q[i];
            fid_d[i] = fid_q[i];
            if (wr_pick[i]) begin
                sel_d[i] = wr_sel_field(reg_wr_data);
                fid_d[i] = wr_fid_field(reg_wr_data);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            for (int i = 0; i < 5; i++) begin
                sel_q[i] <= pin_mode_pkg::SEL_RESET;
                fid_q[i] <= pin_mode_pkg::FID_RESET;
            end
        end else begin
            for (int i = 0; i < 5; i++) begin
                sel_q[i] <= sel_d[i];
                fid_q[i] <= fid_d[i];
            end
        end
    end

    // read mux over the one-hot pick, so a miss or an idle cycle returns zero
    always_comb begin
        rd_data_d = pin_mode_pkg::READ_ZERO;
        for (int i = 0; i < 5; i++) begin
            if (rd_pick[i]) begin
                rd_data_d = read_word(sel_q[i], fid_q[i]);
            end
        end
    end

    // read data stands for one cycle only, then falls back to zero
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rd_data_q <= pin_mode_pkg::READ_ZERO;
        end else begin
            rd_data_q <= rd_data_d;
        end
    end

    // pad controls registered so every output leaves a flop; one cycle behind the field
    always_comb begin
        logic [2:0] p;
        p = PAD_ALL_OFF;
        oe_d = PINS_NONE;
        pu_d = PINS_NONE;
        pd_d = PINS_NONE;
        for (int i = 0; i < 5; i++) begin
            p = pad_decode(sel_q[i], pin_analog[i]);
            oe_d[i] = p[PAD_OE];
            pu_d[i] = p[PAD_PU];
            pd_d[i] = p[PAD_PD];
        end
    end

    // reset value matches a pulled-down input, so the pads agree with the field
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            oe_q <= OE_RESET;
            pu_q <= PU_RESET;
            pd_q <= PD_RESET;
        end else begin
            oe_q <= oe_d;
            pu_q <= pu_d;
            pd_q <= pd_d;
        end
    end

    assign reg_rd_data = rd_data_q;
    assign pad_output_en = oe_q;
    assign pad_pull_up_en = pu_q;
    assign pad_pull_down_en = pd_q;
    // plain wiring of the id flops, no logic in between
    assign pin_function_id = pack_fids(fid_q[0], fid_q[1], fid_q[2], fid_q[3], fid_q[4]);

endmodule : port2_pin_mode_config

/* File: testbench/port2_pin_mode_asserts.sv */
// port checks for the pin mode block
// bound to every port2_pin_mode_config instance
`timescale 1ns/100ps
module port2_pin_mode_checker (
    input wire logic sys_clk, // clock
    input wire logic rst_b, // reset, active low
    input wire logic reg_rd, // read strobe
    input wire logic [15:0] reg_rd_data, // read data
    input wire logic [4:0] pin_analog, // analog use
    input wire logic [4:0] pad_output_en, // driver on
    input wire logic [4:0] pad_pull_up_en, // pull-up on
    input wire logic [4:0] pad_pull_down_en, // pull-down on
    input wire logic [24:0] pin_function_id // ids
);
    default clocking cb @(posedge sys_clk); endclocking
    a_one_pull_only: assert property (disable iff (!rst_b)
        (pad_pull_up_en & pad_pull_down_en) == 5'h00) else $error("both pulls on");
    a_output_no_pull: assert property (disable iff (!rst_b)
        (pad_output_en & (pad_pull_up_en | pad_pull_down_en)) == 5'h00) else $error("pull on output");
    a_analog_all_off: assert property (disable iff (!rst_b) rst_b |=>
        ((pad_output_en | pad_pull_up_en | pad_pull_down_en) & $past(pin_analog)) == 5'h00)
        else $error("analog pin not released");
    a_reset_pull_down: assert property (!rst_b |=> pad_pull_down_en == 5'h1f
        && pad_output_en == 5'h00 && pin_function_id == 25'h0) else $error("bad reset pads");
    a_idle_read_zero: assert property (disable iff (!rst_b)
        !reg_rd |=> reg_rd_data == 16'h0000) else $error("read data without read");
endmodule : port2_pin_mode_checker
bind port2_pin_mode_config port2_pin_mode_checker u_chk (.sys_clk(sys_clk), .rst_b(rst_b),
    .reg_rd(reg_rd), .reg_rd_data(reg_rd_data), .pin_analog(pin_analog),
    .pad_output_en(pad_output_en), .pad_pull_up_en(pad_pull_up_en),
    .pad_pull_down_en(pad_pull_down_en), .pin_function_id(pin_function_id));

/* File: testbench/tb_port2_pin_mode_config.sv */
// bench for the pin mode block: register port and pad decode
// assumes pads trail register fields by one cycle
`timescale 1ns/100ps
module tb_port2_pin_mode_config;
    logic sys_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0;
    logic [31:0] reg_addr = '0;
    logic [15:0] reg_wr_data = '0, reg_rd_data;
    logic [4:0] pin_analog = '0, oe, pu, pd;
    logic [24:0] fid;
    logic [2:0] pads_exp [4] = '{3'h0, 3'h2, 3'h1, 3'h4};
    int error_cnt = 0, check_count = 0;
    port2_pin_mode_config dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rd_data(reg_rd_data), .pin_analog(pin_analog), .pad_output_en(oe),
        .pad_pull_up_en(pu), .pad_pull_down_en(pd), .pin_function_id(fid));
    initial forever #12.5 sys_clk = ~sys_clk;
    task chk(input logic [24:0] got, input logic [24:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task acc(input logic [31:0] a, input logic w, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wr_data <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge sys_clk);
        reg_wr <= 1'h0;
        reg_rd <= 1'h0;
        #1;
    endtask : acc
    function automatic logic [31:0] ofs(input int i);
        return pin_mode_pkg::PORT2_PIN1_MODE_OFS + 32'(2 * i);
    endfunction : ofs
    task reset_values;
        chk(pd, 5'h1f);
        chk(fid, 25'h0);
        for (int i = 0; i < 5; i++) begin
            acc(ofs(i), 1'h0, 16'h0);
            chk(reg_rd_data, 16'h0200);
        end
    endtask : reset_values
    task sel_codes;
        for (int s = 0; s < 4; s++) begin
            acc(ofs(0), 1'h1, {6'h0, 2'(s), 8'h0});
            @(posedge sys_clk);
            #1 chk({oe[0], pu[0], pd[0]}, pads_exp[s]);
            acc(ofs(0), 1'h0, 16'h0);
            chk(reg_rd_data, {6'h0, 2'(s), 8'h0});
        end
    endtask : sel_codes
    task reserved_bits;
        acc(ofs(4), 1'h1, 16'hffff);
        acc(ofs(4), 1'h0, 16'h0);
        chk(reg_rd_data, 16'h031f);
        chk(fid[24:20], 5'h1f);
        acc(32'h5000_3052, 1'h0, 16'h0);
        chk(reg_rd_data, 16'h0);
    endtask : reserved_bits
    task analog_override;
        @(posedge sys_clk);
        pin_analog <= 5'h1f;
        repeat (2) @(posedge sys_clk);
        #1 chk({oe, pu, pd}, 15'h0);
    endtask : analog_override
    task complete_run;
        if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : complete_run
    initial begin
        repeat (20) @(posedge sys_clk);
        rst_b <= 1'h1;
        @(posedge sys_clk);
        #1 reset_values();
        sel_codes();
        reserved_bits();
        analog_override();
        complete_run();
    end
endmodule : tb_port2_pin_mode_config
